// *** rtl/txsi_pkg.sv ***
package txsi_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAG = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CMD  = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int         ADDR_LSB = 2;
  // reset values
  localparam logic [7:0] FLAG_RESET = 8'h08;
  localparam logic [1:0] IDX_EMPTY  = 2'b00;
  // field positions and sizes
  localparam int CTRL_FEAT_BIT = 0;
  localparam int FLAG_IDX_LO   = 6;
  localparam int FLAG_EMP_BIT  = 3;
  localparam int CMD_COMMIT    = 0;
  localparam int CMD_ADVANCE   = 1;
  localparam int STAT_FLUSH    = 0;
  localparam int STAT_OVF      = 1;
  localparam int DATA_W        = 32;
  localparam int FIFO_DEPTH    = 16;
  // per-set age relative to frame boundaries
  typedef enum logic {SET_PENDING, SET_LIVE} txsi_age_t;
  // answer to an IN token
  typedef struct packed {
    logic zlp;
    logic set;
  } txsi_in_resp_t;
endpackage : txsi_pkg

// *** rtl/txsi_top.sv ***
// Summary of operation
// - the flag register sits at offset 0x04 and resets to 0x08, index field empty and bit 3 set.
// - the index field in bits 7:6 is read only and changes only on FIFO events.
// - with frame sync on, a committed set becomes visible only at the next SOF.
// - with frame sync on, an IN before that SOF gets a zero-length answer unless an older set is live.
// - with frame sync on, a set may be sent only in the frame after the SOF that follows its write.
// - a set committed after the SOF of its frame leaves that frame with zero-length answers.
// - a late set is flushed at the next SOF when the correct set was written during its frame.
// - the index field holds one presence bit per set, 00 empty, 01 or 10 one set, 11 both.
`timescale 1ns/100ps
module txsi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rptr_r];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // storage
  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem[wptr_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= wptr_r + AW'(1);
      end
      if (pop)
      begin
        rptr_r <= rptr_r + AW'(1);
      end
      if (push && !pop)
      begin
        count_r <= count_r + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end
endmodule : txsi_fifo

module txsi_top
  import txsi_pkg::*;
#(
  parameter int FIFO_W = DATA_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // usb engine events
  input  wire logic              sof,
  input  wire logic              in_token,
  input  wire logic              in_done,
  // in token answer
  output logic                   in_resp_valid,
  output txsi_in_resp_t          in_resp,
  // data stream to usb engine
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [FIFO_W-1:0]      tx_data,
  // index flags
  output logic [1:0]             tx_set_index_flags
);
  logic          iso_frame_sync_feature;
  logic [1:0]    pres_r;
  logic [1:0]    pres_nxt;
  txsi_age_t     age_r   [2];
  txsi_age_t     age_nxt [2];
  logic          rsel_r;
  logic          rsel_nxt;
  logic          wsel_r;
  logic          wsel_nxt;
  logic          flush_evt;
  logic          ovf_evt;
  logic          stat_flush_r;
  logic          stat_ovf_r;
  logic          cur_empty_r;
  logic          in_resp_valid_r;
  txsi_in_resp_t in_resp_r;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic          acc;
  logic          done;
  logic          wr_data;
  logic          stall;
  logic          commit_evt;
  logic          adv_evt;
  logic          fifo_in_ready;
  logic          oldest_live;
  logic [7:0]    flag_val;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:ADDR_LSB] == ofs[7:ADDR_LSB]);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFS_CTRL) || hit(a, OFS_FLAG) || hit(a, OFS_DATA)
             || hit(a, OFS_CMD) || hit(a, OFS_STAT);
  endfunction : mapped

  // apb handshake
  assign acc        = psel && penable;
  assign done       = acc && pready_r;
  assign wr_data    = pwrite && hit(paddr, OFS_DATA);
  assign stall      = wr_data && !fifo_in_ready;
  assign commit_evt = done && pwrite && hit(paddr, OFS_CMD) && pwdata[CMD_COMMIT];
  assign adv_evt    = in_done || (done && pwrite && hit(paddr, OFS_CMD) && pwdata[CMD_ADVANCE]);
  // oldest set eligible for an IN
  assign oldest_live = pres_r[rsel_r]
                       && (!iso_frame_sync_feature || age_r[rsel_r] == SET_LIVE);
  assign flag_val = {pres_r, 2'b00, cur_empty_r, 3'b000};

  txsi_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (done && wr_data),
    .in_ready  (fifo_in_ready),
    .in_data   (FIFO_W'(pwdata)),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // apb answer one cycle into access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
    else if (ce)
    begin
      pready_r  <= acc && !pready_r && !stall;
      pslverr_r <= acc && !pready_r && !stall && !mapped(paddr);
      prdata_r  <= '0;
      if (acc && !pready_r && !pwrite)
      begin
        if (hit(paddr, OFS_CTRL))
        begin
          prdata_r[CTRL_FEAT_BIT] <= iso_frame_sync_feature;
        end
        else if (hit(paddr, OFS_FLAG))
        begin
          prdata_r[7:0] <= flag_val;
        end
        else if (hit(paddr, OFS_STAT))
        begin
          prdata_r[STAT_FLUSH] <= stat_flush_r;
          prdata_r[STAT_OVF]   <= stat_ovf_r;
        end
      end
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iso_frame_sync_feature <= 1'b0;
    end
    else if (ce && done && pwrite && hit(paddr, OFS_CTRL))
    begin
      iso_frame_sync_feature <= pwdata[CTRL_FEAT_BIT];
    end
  end

  // set tracking next state
  always_comb
  begin
    pres_nxt   = pres_r;
    age_nxt[0] = age_r[0];
    age_nxt[1] = age_r[1];
    rsel_nxt   = rsel_r;
    wsel_nxt   = wsel_r;
    flush_evt  = 1'b0;
    ovf_evt    = 1'b0;
    if (adv_evt && pres_nxt[rsel_nxt])
    begin
      pres_nxt[rsel_nxt] = 1'b0;
      rsel_nxt           = ~rsel_nxt;
    end
    if (commit_evt)
    begin
      if (!pres_nxt[wsel_nxt])
      begin
        pres_nxt[wsel_nxt] = 1'b1;
        age_nxt[wsel_nxt]  = SET_PENDING;
        wsel_nxt           = ~wsel_nxt;
      end
      else
      begin
        ovf_evt = 1'b1;
      end
    end
    if (sof && iso_frame_sync_feature)
    begin
      if (pres_nxt[rsel_nxt] && age_nxt[rsel_nxt] == SET_LIVE
          && pres_nxt[~rsel_nxt] && age_nxt[~rsel_nxt] == SET_PENDING)
      begin
        pres_nxt[rsel_nxt] = 1'b0;
        rsel_nxt           = ~rsel_nxt;
        flush_evt          = 1'b1;
      end
      age_nxt[0] = SET_LIVE;
      age_nxt[1] = SET_LIVE;
    end
  end

  // index field moves only on fifo events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pres_r   <= IDX_EMPTY;
      age_r[0] <= SET_LIVE;
      age_r[1] <= SET_LIVE;
      rsel_r   <= 1'b0;
      wsel_r   <= 1'b0;
    end
    else if (ce)
    begin
      pres_r   <= pres_nxt;
      age_r[0] <= age_nxt[0];
      age_r[1] <= age_nxt[1];
      rsel_r   <= rsel_nxt;
      wsel_r   <= wsel_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_empty_r <= 1'b1;
    end
    else if (ce)
    begin
      if (commit_evt)
      begin
        cur_empty_r <= 1'b1;
      end
      else if (done && wr_data)
      begin
        cur_empty_r <= 1'b0;
      end
    end
  end

  // sticky status, set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_flush_r <= 1'b0;
      stat_ovf_r   <= 1'b0;
    end
    else if (ce)
    begin
      if (done && pwrite && hit(paddr, OFS_STAT))
      begin
        stat_flush_r <= flush_evt || (stat_flush_r && !pwdata[STAT_FLUSH]);
        stat_ovf_r   <= ovf_evt || (stat_ovf_r && !pwdata[STAT_OVF]);
      end
      else
      begin
        stat_flush_r <= stat_flush_r || flush_evt;
        stat_ovf_r   <= stat_ovf_r || ovf_evt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_resp_valid_r <= 1'b0;
      in_resp_r       <= '0;
    end
    else if (ce)
    begin
      in_resp_valid_r <= in_token;
      if (in_token)
      begin
        in_resp_r.zlp <= !oldest_live;
        in_resp_r.set <= rsel_r;
      end
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign in_resp_valid      = in_resp_valid_r;
  assign in_resp            = in_resp_r;
  assign tx_set_index_flags = pres_r;

  a_idx_read_only: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && done && pwrite && hit(paddr, OFS_FLAG) && !sof && !in_done) |=> $stable(pres_r))
    else $error("index field changed by register write");
  a_zlp_pending: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && in_token && iso_frame_sync_feature && !(pres_r[rsel_r] && age_r[rsel_r] == SET_LIVE))
    |=> (in_resp_valid_r && in_resp_r.zlp))
    else $error("pending set answered before sof");
  a_live_sent: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && in_token && pres_r[rsel_r] && age_r[rsel_r] == SET_LIVE)
    |=> (!in_resp_r.zlp && in_resp_r.set == $past(rsel_r)))
    else $error("live set not sent");
  a_commit_pending: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && commit_evt && !sof && !adv_evt && !pres_r[wsel_r])
    |=> (pres_r != $past(pres_r) && wsel_r != $past(wsel_r)))
    else $error("commit did not add a set");
  a_sof_promote: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && sof && iso_frame_sync_feature) |=> (age_r[0] == SET_LIVE && age_r[1] == SET_LIVE))
    else $error("sets not live after sof");
  a_late_flush: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && sof && iso_frame_sync_feature && !adv_evt && !commit_evt && pres_r == 2'b11
     && age_r[rsel_r] == SET_LIVE && age_r[~rsel_r] == SET_PENDING)
    |=> (stat_flush_r && pres_r != 2'b11 && rsel_r != $past(rsel_r)))
    else $error("late set not flushed");
  a_adv_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && adv_evt && !commit_evt && !sof && pres_r == 2'b11)
    |=> (pres_r == 2'b10 || pres_r == 2'b01))
    else $error("advance did not drop oldest set");
  a_empty_commit: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && commit_evt) |=> cur_empty_r)
    else $error("empty flag not set by commit");
  a_nosync_send: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && in_token && !iso_frame_sync_feature && pres_r[rsel_r]) |=> !in_resp_r.zlp)
    else $error("present set withheld without frame sync");
endmodule : txsi_top

// *** test/txsi_host_model.sv ***
`timescale 1ns/100ps
module txsi_host_model
  import txsi_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // usb events
  output logic                   sof,
  output logic                   in_token,
  output logic                   in_done,
  input  wire logic              in_resp_valid,
  input  wire txsi_in_resp_t     in_resp,
  // data stream
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              stall
);
  txsi_in_resp_t     last_resp;
  logic [DATA_W-1:0] got_q[$];

  initial
  begin
    {sof, in_token, in_done} = 3'b000;
  end

  // one-cycle event: 0 sof, 1 in token, 2 in done
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: sof <= 1'b1;
      1: in_token <= 1'b1;
      default: in_done <= 1'b1;
    endcase
    @(posedge pclk);
    {sof, in_token, in_done} <= 3'b000;
  endtask : pulse

  assign tx_ready = !stall;

  always @(posedge pclk)
  begin
    if (in_resp_valid)
      last_resp <= in_resp;
    if (presetn && tx_valid && tx_ready)
      got_q.push_back(tx_data);
  end
endmodule : txsi_host_model

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench
  import txsi_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
  logic              sof, in_token, in_done, in_resp_valid, tx_valid, tx_ready, e, done17, ce;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [DATA_W-1:0] tx_data, exp_q[$];
  logic [1:0]        tx_set_index_flags;
  txsi_in_resp_t     in_resp;
  int                err_count, checks;

  txsi_top dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sof, .in_token, .in_done, .in_resp_valid, .in_resp,
    .tx_valid, .tx_ready, .tx_data, .tx_set_index_flags);
  txsi_host_model host_u (.pclk, .presetn, .sof, .in_token, .in_done, .in_resp_valid,
    .in_resp, .tx_valid, .tx_ready, .tx_data, .stall);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, x, g);
    end
  endtask : chk

  task automatic chk_resp(input txsi_in_resp_t x);
    checks++;
    if (host_u.last_resp !== x)
    begin
      err_count++;
      $display("wrong value in_resp exp %b got %b", x, host_u.last_resp);
    end
  endtask : chk_resp

  // apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      err_count++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, x, q);
  endtask : rd_chk

  task automatic push(input logic [31:0] d);
    apb(1'b1, OFS_DATA, d);
    exp_q.push_back(d);
  endtask : push

  task automatic commit();
    apb(1'b1, OFS_CMD, 32'h0000_0001);
  endtask : commit

  task automatic flg(input logic [1:0] x);
    apb(1'b0, OFS_FLAG, 32'h0000_0000);
    chk("index field", {30'h0, x}, {30'h0, q[7:6]});
    chk("index port", {30'h0, x}, {30'h0, tx_set_index_flags});
  endtask : flg

  task automatic ask(input txsi_in_resp_t x);
    host_u.pulse(1);
    repeat (2) @(posedge pclk);
    chk_resp(x);
  endtask : ask

  initial
  begin
    {psel, penable, pwrite, stall, done17} = '0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("flag reset", OFS_FLAG, 32'h0000_0008);
    apb(1'b1, OFS_FLAG, 32'hffff_ffff);
    rd_chk("flag ro", OFS_FLAG, 32'h0000_0008);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, q);
    push(32'h1111_1111);
    rd_chk("empty flag", OFS_FLAG, 32'h0000_0000);
    commit();
    flg(2'b01);
    ask(2'b00);
    ce <= 1'b0;
    host_u.pulse(2);
    ce <= 1'b1;
    flg(2'b01);
    host_u.pulse(2);
    flg(2'b00);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    rd_chk("feature bit", OFS_CTRL, 32'h0000_0001);
    push(32'h2222_2222);
    commit();
    flg(2'b10);
    ask(2'b11);
    host_u.pulse(0);
    ask(2'b01);
    push(32'h3333_3333);
    commit();
    flg(2'b11);
    ask(2'b01);
    host_u.pulse(0);
    rd_chk("flush flag", OFS_STAT, 32'h0000_0001);
    flg(2'b01);
    ask(2'b00);
    host_u.pulse(2);
    flg(2'b00);
    apb(1'b1, OFS_STAT, 32'h0000_0003);
    repeat (3) commit();
    rd_chk("overflow", OFS_STAT, 32'h0000_0002);
    apb(1'b1, OFS_STAT, 32'h0000_0003);
    rd_chk("status clear", OFS_STAT, 32'h0000_0000);
    host_u.pulse(2);
    flg(2'b01);
    host_u.pulse(2);
    flg(2'b00);
    stall <= 1'b1;
    for (int i = 0; i < 16; i++)
      push(32'ha000_0000 + i);
    fork
      begin
        push(32'ha000_0010);
        done17 = 1'b1;
      end
      begin
        repeat (30) @(posedge pclk);
        chk("full refuses", 32'h0000_0000, {31'h0, done17});
        stall <= 1'b0;
      end
    join
    for (int n = 0; n < 300 && host_u.got_q.size() < exp_q.size(); n++)
      @(posedge pclk);
    chk("drained count", exp_q.size(), host_u.got_q.size());
    foreach (exp_q[i])
      chk("stream word", exp_q[i], host_u.got_q[i]);
    tally_and_finish();
  end
endmodule : testbench
